// ===== dv/coil_function_evaluator_tb.sv
/*
 * Self-checking bench for the coil function evaluator.
 * Assumes the rung model answers each slot index combinationally.
 */
`timescale 1ns/1ps
`include "coil_cfg.svh"
module coil_function_evaluator_tb;
  import coil_pkg::*;
  logic clk = 0, rst = 1, ce = 1, scan_start = 0, halt = 0, power_loss = 0;
  logic [`NUM_RELAYS-1:0] retain_mask = 16'h0000, func_retain_mask = 16'h0000, func_param_hit = 16'h0000;
  coil_mode_t slot_mode;
  relay_idx_t slot_relay;
  logic slot_in, slot_last, scan_done, busy;
  slot_idx_t slot_idx;
  logic [`NUM_RELAYS-1:0] relay_state, func_contact;
  func_val_t func_value [`NUM_RELAYS];
  int fails = 0, checked = 0, cyc = 0;

  coil_function_evaluator i_dut (.clk(clk), .rst(rst), .ce(ce), .scan_start(scan_start), .halt(halt),
    .power_loss(power_loss), .slot_mode(slot_mode), .slot_relay(slot_relay), .slot_in(slot_in),
    .slot_last(slot_last), .retain_mask(retain_mask), .func_retain_mask(func_retain_mask),
    .func_param_hit(func_param_hit), .slot_idx(slot_idx), .relay_state(relay_state),
    .func_contact(func_contact), .func_value(func_value), .scan_done(scan_done), .busy(busy));
  coil_rung_model i_rung (.slot_idx(slot_idx), .slot_mode(slot_mode), .slot_relay(slot_relay),
    .slot_in(slot_in), .slot_last(slot_last));

  always #50 clk = ~clk;

  task end_sim;
    $display("errors %0d checks %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // hang guard, far above the roughly 150 cycles the scans need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      end_sim();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task put(input int i, input coil_mode_t m, input relay_idx_t r, input logic v);
    i_rung.tab_mode[i] = m;
    i_rung.tab_relay[i] = r;
    i_rung.tab_in[i] = v;
  endtask

  task scan(input slot_idx_t last);
    int n;
    i_rung.last_idx = last;
    @(posedge clk);
    #1 scan_start = 1;
    @(posedge clk);
    #1 scan_start = 0;
    n = 0;
    while (scan_done !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    chk(scan_done, 1'b1);
  endtask

  // halt or power loss held for one edge
  task clr(input logic pl);
    @(posedge clk);
    #1 power_loss = pl;
    halt = !pl;
    @(posedge clk);
    #1 power_loss = 0;
    halt = 0;
  endtask

  // four scans of two slots; per scan bit k of a, b feeds the slots
  task run4(input coil_mode_t m0, input relay_idx_t r0, input logic [3:0] a, input coil_mode_t m1,
            input relay_idx_t r1, input logic [3:0] b, input logic [3:0] e0, input logic [3:0] e1);
    clr(0);
    for (int k = 0; k < 4; k++) begin
      put(0, m0, r0, a[k]);
      put(1, m1, r1, b[k]);
      scan(1);
      chk(relay_state[r0], e0[k]);
      chk(relay_state[r1], e1[k]);
    end
  endtask

  task s_inv;
    run4(`MODE_INV, 1, 4'h5, `MODE_CONT, 7, 4'h6, 4'hA, 4'h6);
    put(1, `MODE_CONT, 1, 1'b0);
    scan(1);
    chk(relay_state[1], 1'b0);
  endtask

  task s_edge;
    run4(`MODE_RISE, 2, 4'h3, `MODE_FALL, 3, 4'h3, 4'h1, 4'h4);
  endtask

  task s_imp;
    run4(`MODE_IMP, 4, 4'hB, `MODE_CONT, 7, 4'hB, 4'h7, 4'hB);
  endtask

  task s_latch;
    run4(`MODE_SET, 5, 4'h5, `MODE_RST, 5, 4'hC, 4'h3, 4'h3);
    put(0, `MODE_RST, 5, 1'b1);
    put(1, `MODE_SET, 5, 1'b1);
    scan(1);
    chk(relay_state[5], 1'b1);
  endtask

  task s_clear;
    clr(0);
    retain_mask = 16'h0020;
    put(0, `MODE_SET, 5, 1'b1);
    put(1, `MODE_SET, 6, 1'b1);
    scan(1);
    clr(1);
    chk(relay_state[6:5], 2'h1);
    scan(1);
    clr(0);
    chk(relay_state[6:5], 2'h1);
    retain_mask = 16'h0000;
  endtask

  // freeze mid-scan and while scan_done stands: nothing may move with ce low
  task s_ce;
    clr(0);
    put(0, `MODE_IMP, 8, 1'b1);
    put(1, `MODE_CONT, 9, 1'b1);
    i_rung.last_idx = 5'h01;
    @(posedge clk);
    #1 scan_start = 1;
    @(posedge clk);
    #1 scan_start = 0;
    ce = 0;
    repeat (3) @(posedge clk);
    #1 chk({busy, slot_idx, relay_state[9:8]}, 8'h80);
    ce = 1;
    repeat (3) @(posedge clk);
    #1 chk({scan_done, relay_state[9:8]}, 3'h7);
    ce = 0;
    @(posedge clk);
    #1 chk(scan_done, 1'b1);
    ce = 1;
  endtask

  task s_func;
    clr(0);
    func_retain_mask = 16'h0002;
    func_param_hit = 16'h0001;
    put(0, `MODE_CONT, 1, 1'b0);
    put(1, `MODE_CONT, 1, 1'b1);
    scan(1);
    chk(func_contact[1:0], 2'h3);
    func_param_hit = 16'h0000;
    clr(1);
    chk({func_value[1] != 16'h0000, func_value[0] != 16'h0000}, 2'h2);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    s_inv();
    s_edge();
    s_imp();
    s_latch();
    s_clear();
    s_ce();
    s_func();
    end_sim();
  end
endmodule

// ===== dv/coil_rung_model.sv
/*
 * Rung logic model: slot table read at the evaluator's slot index.
 * Assumes the bench fills the tab_ arrays and last_idx before each scan.
 */
`timescale 1ns/1ps
`include "coil_cfg.svh"
module coil_rung_model
  import coil_pkg::*;
(
  input wire slot_idx_t slot_idx,
  output coil_mode_t slot_mode,
  output relay_idx_t slot_relay,
  output logic slot_in,
  output logic slot_last
);
  coil_mode_t tab_mode [`NUM_SLOTS];
  relay_idx_t tab_relay [`NUM_SLOTS];
  logic tab_in [`NUM_SLOTS];
  slot_idx_t last_idx = 5'h00;
  // edge modes only ever land on flag relays
  assign slot_mode = tab_mode[slot_idx];
  assign slot_relay = tab_relay[slot_idx];
  assign slot_in = tab_in[slot_idx];
  assign slot_last = (slot_idx == last_idx);
endmodule

// ===== hdl/coil_cfg.svh
/*
 * Constants for the coil function evaluator: relay count, coil slot count,
 * mode encodings and reset values. Assumes inclusion by the package and design.
 */
`ifndef COIL_CFG_SVH
`define COIL_CFG_SVH
`define NUM_RELAYS 16
`define REL_W 4
`define NUM_SLOTS 32
`define SLOT_W 5
`define FUNC_VAL_W 16
`define FUNC_VAL_RST 16'h0000
`define FUNC_VAL_ONE 16'h0001
`define MODE_CONT 3'h0
`define MODE_INV 3'h1
`define MODE_FALL 3'h2
`define MODE_RISE 3'h3
`define MODE_IMP 3'h4
`define MODE_SET 3'h5
`define MODE_RST 3'h6
`endif

// ===== hdl/coil_function_evaluator.sv
/*
 * Cyclic coil function evaluator. A scan walks coil slots in rung order
 * (one per cycle), each slot naming a relay, a mode and its input. After
 * the last slot the function relays are updated from the final coil states.
 * Assumes the rung logic presents slot_in for the slot on slot_idx, steady
 * while the scan runs, and that slot table/retention masks are static.
 */
`timescale 1ns/1ps
`include "coil_cfg.svh"
module coil_function_evaluator
  import coil_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scan_start,
  input wire logic halt,
  input wire logic power_loss,
  input wire coil_mode_t slot_mode,
  input wire relay_idx_t slot_relay,
  input wire logic slot_in,
  input wire logic slot_last,
  input wire logic [`NUM_RELAYS-1:0] retain_mask,
  input wire logic [`NUM_RELAYS-1:0] func_retain_mask,
  input wire logic [`NUM_RELAYS-1:0] func_param_hit,
  output slot_idx_t slot_idx,
  output logic [`NUM_RELAYS-1:0] relay_state,
  output logic [`NUM_RELAYS-1:0] func_contact,
  output func_val_t func_value [`NUM_RELAYS],
  output logic scan_done,
  output logic busy
);
  scan_state_e state_q;
  slot_idx_t idx_q;
  logic [`NUM_RELAYS-1:0] rel_q;
  logic [`NUM_SLOTS-1:0] prev_q;
  logic [`NUM_RELAYS-1:0] fc_q;
  func_val_t fv_q [`NUM_RELAYS];
  logic done_q;
  logic clear;
  logic new_state;

  // clear wins over any scan activity; everything below obeys it
  assign clear = halt | power_loss;
  assign slot_idx = idx_q;
  assign relay_state = rel_q;
  assign func_contact = fc_q;
  assign func_value = fv_q;
  assign scan_done = done_q;
  assign busy = (state_q != ST_IDLE);

  coil_slot_eval u_eval (
    .mode(slot_mode),
    .coil_in(slot_in),
    .coil_prev(prev_q[idx_q]),
    .state_in(rel_q[slot_relay]),
    .state_out(new_state)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      idx_q <= '0;
    end else if (ce) begin
      if (clear) begin
        state_q <= ST_IDLE;
        idx_q <= '0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            if (scan_start) begin
              state_q <= ST_PASS;
              idx_q <= '0;
            end
          end
          ST_PASS: begin
            if (slot_last || idx_q == slot_idx_t'(`NUM_SLOTS-1)) begin
              state_q <= ST_FUNC;
            end else begin
              idx_q <= idx_q + slot_idx_t'(1);
            end
          end
          ST_FUNC: state_q <= ST_IDLE;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // slots applied in rung order, so later writes overwrite earlier ones
  always_ff @(posedge clk) begin
    if (rst) begin
      rel_q <= '0;
    end else if (ce) begin
      if (clear) begin
        rel_q <= rel_q & retain_mask;
      end else if (state_q == ST_PASS) begin
        rel_q[slot_relay] <= new_state;
      end
    end
  end

  // edge history per slot, so each coil slot has its own previous value
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= '0;
    end else if (ce) begin
      if (clear) begin
        prev_q <= '0;
      end else if (state_q == ST_PASS) begin
        prev_q[idx_q] <= slot_in;
      end
    end
  end

  // function relays: coil drive or parameter hit starts them; simple model
  // counts start events as actual value, contact follows a nonzero value
  always_ff @(posedge clk) begin
    if (rst) begin
      fc_q <= '0;
      for (int i = 0; i < `NUM_RELAYS; i++) begin
        fv_q[i] <= `FUNC_VAL_RST;
      end
    end else if (ce) begin
      if (clear) begin
        for (int i = 0; i < `NUM_RELAYS; i++) begin
          if (!func_retain_mask[i]) begin
            fv_q[i] <= `FUNC_VAL_RST;
            fc_q[i] <= 1'b0;
          end
        end
      end else if (state_q == ST_FUNC) begin
        for (int i = 0; i < `NUM_RELAYS; i++) begin
          if (rel_q[i] || func_param_hit[i]) begin
            fv_q[i] <= fv_q[i] + `FUNC_VAL_ONE;
            fc_q[i] <= 1'b1;
          end else begin
            fc_q[i] <= (fv_q[i] != `FUNC_VAL_RST);
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= (state_q == ST_FUNC) && !clear;
    end
  end

  property p_clear_relays;
    @(posedge clk) disable iff (rst)
      (ce && clear) |=> ((rel_q & ~$past(retain_mask)) == '0);
  endproperty
  a_clear_relays: assert property (p_clear_relays) else $error("non-retentive coil survived clear");

  property p_func_clear;
    @(posedge clk) disable iff (rst)
      (ce && clear && !func_retain_mask[0]) |=> (fv_q[0] == `FUNC_VAL_RST);
  endproperty
  a_func_clear: assert property (p_func_clear) else $error("function value kept on clear");

  property p_func_after_pass;
    @(posedge clk) disable iff (rst)
      (state_q == ST_FUNC) |-> ($past(state_q) == ST_PASS || ($past(state_q) == ST_FUNC && !$past(ce)));
  endproperty
  a_func_after_pass: assert property (p_func_after_pass) else $error("function stage without pass");

  property p_done_pulse;
    @(posedge clk) disable iff (rst)
      (scan_done && ce) |=> !scan_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("scan_done longer than one cycle");

  property p_inv;
    @(posedge clk) disable iff (rst)
      (ce && !clear && state_q == ST_PASS && slot_mode == `MODE_INV) |=> rel_q[$past(slot_relay)] == !$past(slot_in);
  endproperty
  a_inv: assert property (p_inv) else $error("inverse contact wrong");

  property p_rise;
    @(posedge clk) disable iff (rst)
      (ce && !clear && state_q == ST_PASS && slot_mode == `MODE_RISE)
        |=> rel_q[$past(slot_relay)] == ($past(slot_in) && !$past(prev_q[idx_q]));
  endproperty
  a_rise: assert property (p_rise) else $error("rising pulse wrong");

  property p_fall;
    @(posedge clk) disable iff (rst)
      (ce && !clear && state_q == ST_PASS && slot_mode == `MODE_FALL)
        |=> rel_q[$past(slot_relay)] == (!$past(slot_in) && $past(prev_q[idx_q]));
  endproperty
  a_fall: assert property (p_fall) else $error("falling pulse wrong");

  property p_imp;
    @(posedge clk) disable iff (rst)
      (ce && !clear && state_q == ST_PASS && slot_mode == `MODE_IMP && slot_in && !prev_q[idx_q])
        |=> rel_q[$past(slot_relay)] != $past(rel_q[slot_relay]);
  endproperty
  a_imp: assert property (p_imp) else $error("impulse relay did not toggle");

  property p_set;
    @(posedge clk) disable iff (rst)
      (ce && !clear && state_q == ST_PASS && slot_mode == `MODE_SET && slot_in) |=> rel_q[$past(slot_relay)];
  endproperty
  a_set: assert property (p_set) else $error("set coil did not latch");

  property p_reset;
    @(posedge clk) disable iff (rst)
      (ce && !clear && state_q == ST_PASS && slot_mode == `MODE_RST && slot_in) |=> !rel_q[$past(slot_relay)];
  endproperty
  a_reset: assert property (p_reset) else $error("reset coil did not clear");

  property p_edge_hist;
    @(posedge clk) disable iff (rst)
      (ce && !clear && state_q == ST_PASS) |=> prev_q[$past(idx_q)] == $past(slot_in);
  endproperty
  a_edge_hist: assert property (p_edge_hist) else $error("edge history not stored");

  property p_func_start;
    @(posedge clk) disable iff (rst)
      (ce && !clear && state_q == ST_FUNC && func_param_hit[0]) |=> fc_q[0];
  endproperty
  a_func_start: assert property (p_func_start) else $error("function relay not started");
endmodule

// ===== hdl/coil_pkg.sv
/*
 * Types for the coil function evaluator.
 * Assumes coil_cfg.svh supplies the numeric constants.
 */
`include "coil_cfg.svh"
package coil_pkg;
  typedef logic [2:0] coil_mode_t;
  typedef logic [`REL_W-1:0] relay_idx_t;
  typedef logic [`SLOT_W-1:0] slot_idx_t;
  typedef logic [`FUNC_VAL_W-1:0] func_val_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PASS = 2'b01,
    ST_FUNC = 2'b10
  } scan_state_e;
endpackage

// ===== hdl/coil_slot_eval.sv
/*
 * Evaluates one coil slot: given the mode, the current input, the input of
 * the previous scan and the relay's present state, returns the new state.
 * Purely combinational; assumes caller holds edge history.
 */
`timescale 1ns/1ps
`include "coil_cfg.svh"
module coil_slot_eval
  import coil_pkg::*;
(
  input wire coil_mode_t mode,
  input wire logic coil_in,
  input wire logic coil_prev,
  input wire logic state_in,
  output logic state_out
);
  logic rise;
  logic fall;
  assign rise = coil_in & ~coil_prev;
  assign fall = ~coil_in & coil_prev;
  always_comb begin
    state_out = state_in;
    unique case (mode)
      `MODE_CONT: state_out = coil_in;
      `MODE_INV: state_out = ~coil_in;
      `MODE_FALL: state_out = fall;
      `MODE_RISE: state_out = rise;
      `MODE_IMP: state_out = state_in ^ rise;
      `MODE_SET: state_out = state_in | coil_in;
      `MODE_RST: state_out = state_in & ~coil_in;
      default: state_out = state_in;
    endcase
  end
endmodule
